// File: verilog/cda_pkg.sv
// Package for the complement / decimal adjust ALU slice.
// Assumes an 8-bit core with byte-wide data memory and working register.
package cda_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam logic [7:0] WORK_RESET = 8'h00;
	localparam logic [3:0] NIBBLE_MAX = 4'h9;
	localparam logic [7:0] CORR_NONE = 8'h00;
	localparam logic [7:0] CORR_LOW = 8'h06;
	localparam logic [7:0] CORR_HIGH = 8'h60;
	localparam logic [7:0] CORR_BOTH = 8'h66;
	// Operation select codes
	typedef enum logic [1:0] {
		CDA_OP_NONE = 2'h0,
		CDA_OP_INV_MEM = 2'h1,
		CDA_OP_INV_REG = 2'h2,
		CDA_OP_DEC_ADJ = 2'h3
	} cda_op_t;
	// Sequencer states, Gray along idle-read-exec
	typedef enum logic [1:0] {
		CDA_ST_IDLE = 2'h0,
		CDA_ST_READ = 2'h1,
		CDA_ST_EXEC = 2'h3
	} cda_state_t;
endpackage : cda_pkg

// File: verilog/cda_calc_if.sv
// Interface between the ALU sequencer and its arithmetic core.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface cda_calc_if;
	logic [7:0] operand;
	logic [7:0] work;
	logic aux_carry_in;
	logic carry_in;
	logic [7:0] inverted;
	logic [7:0] adjusted;
	logic carry_out;
	modport seq (output operand, output work, output aux_carry_in,
		output carry_in, input inverted, input adjusted, input carry_out);
	modport calc (input operand, input work, input aux_carry_in,
		input carry_in, output inverted, output adjusted, output carry_out);
endinterface : cda_calc_if
`default_nettype wire

// File: verilog/cda_calc.sv
// Combinational complement and decimal adjust arithmetic.
// Assumes inputs are stable registered values from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module cda_calc (
	cda_calc_if.calc c
);
	logic low_fix;
	logic high_fix;
	logic [7:0] corr;
	logic [8:0] sum;
	always_comb begin
		low_fix = (c.work[3:0] > cda_pkg::NIBBLE_MAX) || c.aux_carry_in; // RULE4
		high_fix = (c.work[7:4] > cda_pkg::NIBBLE_MAX) || c.carry_in; // RULE5
		case ({high_fix, low_fix})
			2'h0: corr = cda_pkg::CORR_NONE;
			2'h1: corr = cda_pkg::CORR_LOW;
			2'h2: corr = cda_pkg::CORR_HIGH;
			default: corr = cda_pkg::CORR_BOTH;
		endcase
		sum = {1'b0, c.work} + {1'b0, corr}; // RULE6
	end
	assign c.inverted = ~c.operand;
	assign c.adjusted = sum[7:0];
	// Carry stays set on entry so chained decimal adds keep it
	assign c.carry_out = sum[8] | c.carry_in; // RULE7
endmodule : cda_calc
`default_nettype wire

// File: verilog/cda_alu.sv
// Function
// RULE1 - Memory invert writes the complemented byte back and sets zero.
// RULE2 - Register invert loads the complemented byte and sets zero.
// RULE3 - Register invert never writes data memory.
// RULE4 - Low nibble gets six when above nine or aux carry is set.
// RULE5 - High nibble gets six when above nine or carry is set.
// RULE6 - Adjust result is work plus 00, 06, 60 or 66 hex into memory.
// RULE7 - Adjust changes only carry, set when the decimal sum passes 100.
// RULE8 - Adjust leaves the working register untouched.
// Top of the complement / decimal adjust ALU slice.
// Assumes the sequencer holds op and address valid while start is high and that
// data memory answers a read within the cycle that mem_rd stands.
`timescale 1ns/1ps
`default_nettype none
module cda_alu (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Sequencer
	input wire logic start,
	input wire logic [1:0] op,
	input wire logic [7:0] addr,
	input wire logic aux_carry_flag,
	input wire logic carry_in,
	output logic busy,
	output logic done,
	// Data memory
	output logic mem_rd,
	output logic mem_wr,
	output logic [7:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	// Working register and flags
	input wire logic [7:0] work_load,
	input wire logic work_load_en,
	output logic [7:0] work_register,
	output logic zero_flag,
	output logic carry_flag,
	output logic zero_wr,
	output logic carry_wr
);
	cda_calc_if cif ();
	cda_calc u_calc (.c(cif.calc));

	cda_pkg::cda_state_t state_reg, state_next;
	cda_pkg::cda_op_t op_reg, op_next;
	logic [7:0] addr_reg, addr_next;
	logic [7:0] opnd_reg, opnd_next;
	logic ac_reg, ac_next, cy_reg, cy_next;
	logic busy_next, done_next, rd_next, wr_next;
	logic [7:0] wdata_next, work_next;
	logic zero_next, carry_next, zwr_next, cwr_next;

	assign cif.operand = opnd_reg;
	assign cif.work = work_register;
	assign cif.aux_carry_in = ac_reg;
	assign cif.carry_in = cy_reg;

	// Zero test shared by both invert paths
	function automatic logic cda_is_zero(input logic [7:0] v);
		cda_is_zero = (v == 8'h00);
	endfunction : cda_is_zero

	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		addr_next = addr_reg;
		opnd_next = opnd_reg;
		ac_next = ac_reg;
		cy_next = cy_reg;
		busy_next = busy;
		done_next = 1'b0;
		rd_next = 1'b0;
		wr_next = 1'b0;
		wdata_next = mem_wdata;
		work_next = work_register;
		zero_next = zero_flag;
		carry_next = carry_flag;
		zwr_next = 1'b0;
		cwr_next = 1'b0;
		if (work_load_en && state_reg == cda_pkg::CDA_ST_IDLE) begin
			work_next = work_load;
		end
		case (state_reg)
			cda_pkg::CDA_ST_IDLE: begin
				if (start && op != 2'h0) begin
					op_next = cda_pkg::cda_op_t'(op);
					addr_next = addr;
					ac_next = aux_carry_flag;
					cy_next = carry_in;
					busy_next = 1'b1;
					if (op == 2'h3) begin
						state_next = cda_pkg::CDA_ST_EXEC;
					end else begin
						rd_next = 1'b1;
						state_next = cda_pkg::CDA_ST_READ;
					end
				end
			end
			cda_pkg::CDA_ST_READ: begin
				opnd_next = mem_rdata;
				state_next = cda_pkg::CDA_ST_EXEC;
			end
			cda_pkg::CDA_ST_EXEC: begin
				state_next = cda_pkg::CDA_ST_IDLE;
				busy_next = 1'b0;
				done_next = 1'b1;
				case (op_reg)
					cda_pkg::CDA_OP_INV_MEM: begin
						wr_next = 1'b1; // RULE1
						wdata_next = cif.inverted; // RULE1
						zero_next = cda_is_zero(cif.inverted); // RULE1
						zwr_next = 1'b1;
					end
					cda_pkg::CDA_OP_INV_REG: begin
						// No memory write on this path
						work_next = cif.inverted; // RULE2 RULE3
						zero_next = cda_is_zero(cif.inverted); // RULE2
						zwr_next = 1'b1;
					end
					default: begin
						// Work register held; only carry is touched
						wr_next = 1'b1; // RULE6 RULE8
						wdata_next = cif.adjusted; // RULE6
						carry_next = cif.carry_out; // RULE7
						cwr_next = 1'b1; // RULE7
					end
				endcase
			end
			default: begin
				state_next = cda_pkg::CDA_ST_IDLE;
				busy_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= cda_pkg::CDA_ST_IDLE;
			op_reg <= cda_pkg::CDA_OP_NONE;
			addr_reg <= 8'h00;
			opnd_reg <= 8'h00;
			ac_reg <= 1'b0;
			cy_reg <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_wdata <= 8'h00;
			work_register <= cda_pkg::WORK_RESET;
			zero_flag <= 1'b0;
			carry_flag <= 1'b0;
			zero_wr <= 1'b0;
			carry_wr <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			op_reg <= op_next;
			addr_reg <= addr_next;
			opnd_reg <= opnd_next;
			ac_reg <= ac_next;
			cy_reg <= cy_next;
			busy <= busy_next;
			done <= done_next;
			mem_rd <= rd_next;
			mem_wr <= wr_next;
			mem_wdata <= wdata_next;
			work_register <= work_next;
			zero_flag <= zero_next;
			carry_flag <= carry_next;
			zero_wr <= zwr_next;
			carry_wr <= cwr_next;
		end
	end

	// Address register doubles as the memory address output
	assign mem_addr = addr_reg;

	chk_inv_mem_zero: assert property (@(posedge clk) // RULE1
		disable iff (!resetn)
		(mem_wr && op_reg == cda_pkg::CDA_OP_INV_MEM && zero_wr) |->
		(zero_flag == (mem_wdata == 8'h00) && mem_wdata == ~opnd_reg))
		else $error("memory invert result or zero wrong");
	chk_inv_reg_val: assert property (@(posedge clk) // RULE2
		disable iff (!resetn)
		(done && op_reg == cda_pkg::CDA_OP_INV_REG) |->
		(work_register == ~opnd_reg &&
		zero_flag == (work_register == 8'h00)))
		else $error("register invert result wrong");
	chk_inv_reg_nowr: assert property (@(posedge clk) // RULE3
		disable iff (!resetn)
		(op_reg == cda_pkg::CDA_OP_INV_REG && busy) |=> !mem_wr)
		else $error("register invert wrote memory");
	chk_adj_low: assert property (@(posedge clk) // RULE4
		disable iff (!resetn)
		(done && op_reg == cda_pkg::CDA_OP_DEC_ADJ &&
		work_register[3:0] <= cda_pkg::NIBBLE_MAX && !ac_reg &&
		!cy_reg && work_register[7:4] <= cda_pkg::NIBBLE_MAX) |->
		mem_wdata == work_register)
		else $error("needless low nibble fix");
	chk_adj_low_fix: assert property (@(posedge clk) // RULE4
		disable iff (!resetn)
		(done && op_reg == cda_pkg::CDA_OP_DEC_ADJ &&
		(work_register[3:0] > cda_pkg::NIBBLE_MAX || ac_reg)) |->
		(mem_wdata - work_register == 8'h06 ||
		mem_wdata - work_register == 8'h66))
		else $error("low nibble fix missing");
	chk_adj_high: assert property (@(posedge clk) // RULE5
		disable iff (!resetn)
		(done && op_reg == cda_pkg::CDA_OP_DEC_ADJ &&
		(work_register[7:4] > cda_pkg::NIBBLE_MAX || cy_reg)) |->
		(carry_flag && (mem_wdata - work_register == 8'h60 ||
		mem_wdata - work_register == 8'h66)))
		else $error("carry lost on high fix");
	chk_adj_value: assert property (@(posedge clk) // RULE6
		disable iff (!resetn)
		(done && op_reg == cda_pkg::CDA_OP_DEC_ADJ) |->
		(mem_wr && (mem_wdata - work_register == 8'h00 ||
		mem_wdata - work_register == 8'h06 ||
		mem_wdata - work_register == 8'h60 ||
		mem_wdata - work_register == 8'h66)))
		else $error("adjust correction not in set");
	chk_adj_flags: assert property (@(posedge clk) // RULE7
		disable iff (!resetn)
		(done && op_reg == cda_pkg::CDA_OP_DEC_ADJ) |->
		(!zero_wr && carry_wr && $stable(zero_flag)))
		else $error("adjust touched zero");
	chk_adj_work: assert property (@(posedge clk) // RULE8
		disable iff (!resetn)
		(busy && op_reg == cda_pkg::CDA_OP_DEC_ADJ) |=>
		$stable(work_register))
		else $error("adjust changed work register");
endmodule : cda_alu
`default_nettype wire

// File: tb/cda_mem_model.sv
// Data memory model standing beside the ALU slice.
// Assumes one-cycle registered read and write strobes from the ALU.
`timescale 1ns/1ps
`default_nettype none
module cda_mem_model (
	// Clock
	input wire logic clk,
	// Memory port
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [256];
	logic [7:0] held = 8'h00;
	logic hold = 1'b0;
	// Plain always so the bench may preload the array
	always @(posedge clk) begin
		hold <= mem_rd;
		if (mem_rd)
			held <= mem[mem_addr];
		if (mem_wr)
			mem[mem_addr] <= mem_wdata;
	end
	// Valid with the strobe and one cycle after; inverted junk otherwise
	assign mem_rdata = mem_rd ? mem[mem_addr] : (hold ? held : ~held);
endmodule : cda_mem_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the complement / decimal adjust ALU slice.
// Assumes the memory model answers reads and takes writes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	miscompares++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb_top;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic start = 1'b0;
	logic [1:0] op = 2'h0;
	logic [7:0] addr = 8'h00;
	logic ac = 1'b0;
	logic cin = 1'b0;
	logic [7:0] work_load = 8'h00;
	logic work_load_en = 1'b0;
	logic clk_en = 1'b1;
	logic zw_seen = 1'b0;
	logic cw_seen = 1'b0;
	logic busy, done, mem_rd, mem_wr, zero_flag, carry_flag, zero_wr, carry_wr;
	logic [7:0] mem_addr, mem_wdata, mem_rdata, work_register;
	int miscompares = 0;
	int samples_checked = 0;
	always #20 clk = ~clk;
	cda_alu dut (.clk(clk), .resetn(resetn), .clk_en(clk_en), .start(start),
		.op(op), .addr(addr), .aux_carry_flag(ac), .carry_in(cin),
		.busy(busy), .done(done), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.work_load(work_load), .work_load_en(work_load_en),
		.work_register(work_register), .zero_flag(zero_flag),
		.carry_flag(carry_flag), .zero_wr(zero_wr), .carry_wr(carry_wr));
	cda_mem_model mem (.clk(clk), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	task automatic conclude();
		$display("Checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	// One op; extra cycle lets the final memory write land
	task automatic run_op(input logic [1:0] o, input logic [7:0] a,
		input logic f_ac, input logic f_c);
		int n;
		@(negedge clk);
		start = 1'b1;
		op = o;
		addr = a;
		ac = f_ac;
		cin = f_c;
		@(negedge clk);
		start = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		if (done !== 1'b1) begin
			miscompares++;
			conclude();
		end
		zw_seen = zero_wr;
		cw_seen = carry_wr;
		@(negedge clk);
	endtask : run_op
	task automatic load_work(input logic [7:0] v);
		@(negedge clk);
		work_load = v;
		work_load_en = 1'b1;
		@(negedge clk);
		work_load_en = 1'b0;
	endtask : load_work
	task automatic test_inv_mem();
		mem.mem[8'h10] = 8'h5A;
		mem.mem[8'h11] = 8'hFF;
		run_op(cda_pkg::CDA_OP_INV_MEM, 8'h10, 1'b0, 1'b0);
		`CHK("inv mem data", 8'hA5, mem.mem[8'h10])
		`CHK("inv mem zero", 1'b0, zero_flag)
		run_op(cda_pkg::CDA_OP_INV_MEM, 8'h11, 1'b0, 1'b0);
		`CHK("inv mem zero set", 1'b1, zero_flag)
		`CHK("inv mem zero wr", 1'b1, zw_seen)
	endtask : test_inv_mem
	task automatic test_inv_reg();
		mem.mem[8'h20] = 8'h0F;
		mem.mem[8'h21] = 8'hFF;
		run_op(cda_pkg::CDA_OP_INV_REG, 8'h20, 1'b0, 1'b0);
		`CHK("inv reg work", 8'hF0, work_register)
		`CHK("inv reg zero", 1'b0, zero_flag)
		`CHK("inv reg mem kept", 8'h0F, mem.mem[8'h20])
		run_op(cda_pkg::CDA_OP_INV_REG, 8'h21, 1'b0, 1'b0);
		`CHK("inv reg zero set", 1'b1, zero_flag)
		`CHK("inv reg zero wr", 1'b1, zw_seen)
		`CHK("inv reg mem kept ff", 8'hFF, mem.mem[8'h21])
	endtask : test_inv_reg
	// Corrections 00, 06, 06 by aux carry, 60, 60 by carry, 66
	task automatic test_dec_adj();
		logic [7:0] w [6] = '{8'h19, 8'h1B, 8'h12, 8'hA2, 8'h32, 8'hAA};
		logic [7:0] r [6] = '{8'h19, 8'h21, 8'h18, 8'h02, 8'h92, 8'h10};
		logic [1:0] f [6] = '{2'b00, 2'b00, 2'b10, 2'b00, 2'b01, 2'b00};
		logic [5:0] cy = 6'b111000;
		logic z;
		for (int i = 0; i < 6; i++) begin
			load_work(w[i]);
			z = zero_flag;
			run_op(cda_pkg::CDA_OP_DEC_ADJ, 8'(8'h30 + i), f[i][1], f[i][0]);
			`CHK("adjust result", r[i], mem.mem[8'(8'h30 + i)])
			`CHK("adjust carry", cy[i], carry_flag)
			`CHK("adjust zero kept", z, zero_flag)
			`CHK("adjust work kept", w[i], work_register)
			`CHK("adjust zero wr", 1'b0, zw_seen)
			`CHK("adjust carry wr", 1'b1, cw_seen)
		end
	endtask : test_dec_adj
	// Enable low mid-read must hold busy, mem_rd, mem_addr and the memory byte until released
	task automatic test_freeze();
		mem.mem[8'h40] = 8'h3C;
		@(negedge clk);
		start = 1'b1;
		op = cda_pkg::CDA_OP_INV_MEM;
		addr = 8'h40;
		@(negedge clk);
		start = 1'b0;
		clk_en = 1'b0;
		repeat (4) @(negedge clk);
		`CHK("frozen busy", 1'b1, busy)
		`CHK("frozen read", 1'b1, mem_rd)
		`CHK("frozen addr", 8'h40, mem_addr)
		`CHK("frozen mem", 8'h3C, mem.mem[8'h40])
		clk_en = 1'b1;
		repeat (3) @(negedge clk);
		`CHK("thawed mem", 8'hC3, mem.mem[8'h40])
	endtask : test_freeze
	initial begin
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		test_inv_mem();
		test_inv_reg();
		test_dec_adj();
		test_freeze();
		conclude();
	end
endmodule : tb_top
`default_nettype wire
